// [core/sea_engine.sv]
// Command engine of a 256-byte two-wire serial EEPROM slave.
// Assumes an external master drives scl; sda is open drain, pulled up outside.
// Behaviour
// - after write address ack, ack and load next byte into word pointer
// - ack word address and data; start write cycle on stop
// - ignore all inputs while the write cycle runs
// - page write is a byte write plus up to fifteen more bytes
// - acknowledge every complete data byte of a page write
// - pointer advances by one after each received data byte
// - beyond sixteen bytes the pointer rolls over and overwrites
// - fewer than sixteen bytes program only those addresses
// - no slave ack while busy; ack again once the cycle ends
// - write lock high: ack addresses, not data, no write cycle
// - write lock low: every location is writable
// - pointer holds last accessed address plus one
// - read address acked, then eight bits from pointer location
// - no ack plus stop ends reading, back to standby
// - sequential read sends next byte on each master ack
// - read pointer wraps from last location to first
// - last address bit is direction, one means read
// - every byte goes most significant bit first
// - no ack in ninth clock: stop sending, wait for stop
`timescale 1ns/100ps
`include "sea_map.svh"
module sea_engine #(
  parameter int PAGE_W = 4,
  parameter logic [3:0] DEV_ID = 4'h5, // Arbitrary identifier value
  parameter int WR_CYCLES = (`SEA_T_WR_NS * `SEA_CLK_MHZ) / 1000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_write_lock,
  input wire logic [2:0] i_chip_select_straps,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_busy
);

  localparam int PAGE_N = 1 << PAGE_W;
  localparam int BW = $clog2(WR_CYCLES + 1);

  sea_pkg::sea_state_t state;
  sea_pkg::sea_role_t role;
  logic [5:0] sync_q;
  logic scl_s, sda_s, wp, scl_q, sda_q;
  logic [2:0] straps;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [3:0] cnt;
  logic [7:0] sr, tx, ptr, rd_byte;
  logic rw, sda_drive, busy;
  logic byte_done, addr_hit, word_take, data_take, rd_load;
  logic commit_go, commit_we;
  logic [PAGE_N-1:0] valid;
  logic [7:0] pbuf [PAGE_N];
  logic [7:0] mem [256];
  logic [PAGE_W:0] cidx;
  logic [7-PAGE_W:0] cpage;
  logic [7:0] tx_ref;
  logic [BW-1:0] busy_len;

  // Pins cross into the clock domain before anything looks at them
  sea_sync #(.W(6), .RST(`SEA_SYNC_RST)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d({i_scl, i_sda, i_write_lock, i_chip_select_straps}),
    .o_q(sync_q)
  );

  assign {scl_s, sda_s, wp, straps} = sync_q;

  // Previous line levels for edge and condition detection
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Line events; start and stop gated off while the write cycle runs, clock edges not
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_ev = !busy && scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = !busy && scl_s && scl_q && !sda_q && sda_s;

  // Byte decisions
  assign byte_done = (state == sea_pkg::SEA_RECV) && scl_fall && (cnt == `SEA_BYTE_BITS);
  assign addr_hit = (sr[7:1] == {DEV_ID, straps});
  assign word_take = byte_done && (role == sea_pkg::SEA_ROLE_WORD);
  assign data_take = byte_done && (role == sea_pkg::SEA_ROLE_DATA) && !wp;
  assign rd_load = scl_fall && (((state == sea_pkg::SEA_ACK) && (role == sea_pkg::SEA_ROLE_ADDR)
                   && rw) || (state == sea_pkg::SEA_MACK));
  assign rd_byte = mem[ptr];

  // Only a stop after accepted data starts programming
  assign commit_go = stop_ev && (|valid) && !wp;

  // Serial protocol sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= sea_pkg::SEA_IDLE;
      role <= sea_pkg::SEA_ROLE_ADDR;
      cnt <= 4'h0;
      sr <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      sda_drive <= 1'b0;
    end else if (busy) begin
      state <= sea_pkg::SEA_IDLE;
      sda_drive <= 1'b0;
    end else if (stop_ev) begin
      state <= sea_pkg::SEA_IDLE;
      sda_drive <= 1'b0;
    end else if (start_ev) begin
      // A repeated start restarts addressing, which gives the random read
      state <= sea_pkg::SEA_RECV;
      role <= sea_pkg::SEA_ROLE_ADDR;
      cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        sea_pkg::SEA_RECV: begin
          if (scl_rise) begin
            sr <= {sr[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end else if (byte_done) begin
            case (role)
              sea_pkg::SEA_ROLE_ADDR: begin
                if (addr_hit) begin
                  rw <= sr[`SEA_RW_POS];
                  sda_drive <= 1'b1;
                  state <= sea_pkg::SEA_ACK;
                end else begin
                  state <= sea_pkg::SEA_WAIT;
                end
              end
              sea_pkg::SEA_ROLE_WORD: begin
                sda_drive <= 1'b1;
                state <= sea_pkg::SEA_ACK;
              end
              sea_pkg::SEA_ROLE_DATA: begin
                if (wp) begin
                  state <= sea_pkg::SEA_WAIT;
                end else begin
                  sda_drive <= 1'b1;
                  state <= sea_pkg::SEA_ACK;
                end
              end
              default: state <= sea_pkg::SEA_WAIT;
            endcase
          end
        end
        sea_pkg::SEA_ACK: begin
          // Release after the ninth clock, then either send or listen
          if (scl_fall) begin
            cnt <= 4'h0;
            if (role == sea_pkg::SEA_ROLE_ADDR && rw) begin
              tx <= rd_byte;
              sda_drive <= ~rd_byte[7];
              state <= sea_pkg::SEA_SEND;
            end else begin
              sda_drive <= 1'b0;
              state <= sea_pkg::SEA_RECV;
              role <= (role == sea_pkg::SEA_ROLE_ADDR) ? sea_pkg::SEA_ROLE_WORD
                      : sea_pkg::SEA_ROLE_DATA;
            end
          end
        end
        sea_pkg::SEA_SEND: begin
          if (scl_fall) begin
            if (cnt == `SEA_LAST_TX) begin
              sda_drive <= 1'b0;
              state <= sea_pkg::SEA_MACK;
            end else begin
              cnt <= cnt + 4'h1;
              tx <= {tx[6:0], 1'b0};
              sda_drive <= ~tx[6];
            end
          end
        end
        sea_pkg::SEA_MACK: begin
          if (scl_rise && sda_s) begin
            state <= sea_pkg::SEA_WAIT;
          end else if (scl_fall) begin
            tx <= rd_byte;
            sda_drive <= ~rd_byte[7];
            cnt <= 4'h0;
            state <= sea_pkg::SEA_SEND;
          end
        end
        sea_pkg::SEA_IDLE, sea_pkg::SEA_WAIT: state <= state;
        default: state <= sea_pkg::SEA_IDLE;
      endcase
    end
  end

  // Open drain: the pad only ever pulls low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_drive;
  assign o_busy = busy;

  // Word pointer; writes wrap within the page, reads across the array
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr <= `SEA_PTR_RST;
    end else if (word_take) begin
      ptr <= sr;
    end else if (data_take) begin
      ptr <= {ptr[7:PAGE_W], PAGE_W'(ptr[PAGE_W-1:0] + 1'b1)};
    end else if (rd_load) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Page buffer entries: a later byte at the same slot overwrites
  for (genvar g = 0; g < PAGE_N; g++) begin : g_page
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        valid[g] <= 1'b0;
        pbuf[g] <= 8'h00;
      end else if (data_take && ptr[PAGE_W-1:0] == PAGE_W'(g)) begin
        valid[g] <= 1'b1;
        pbuf[g] <= sr;
      end else if (start_ev || (commit_we && cidx[PAGE_W-1:0] == PAGE_W'(g))) begin
        valid[g] <= 1'b0;
      end
    end
  end

  // Programming walks the page once; WR_CYCLES must cover PAGE_N clocks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cidx <= {1'b1, {PAGE_W{1'b0}}};
      cpage <= '0;
    end else if (commit_go) begin
      cidx <= '0;
      cpage <= ptr[7:PAGE_W];
    end else if (!cidx[PAGE_W]) begin
      cidx <= cidx + 1'b1;
    end
  end

  assign commit_we = !cidx[PAGE_W] && valid[cidx[PAGE_W-1:0]];

  // Array keeps no reset: it models nonvolatile content
  always_ff @(posedge i_clk) begin
    if (commit_we) begin
      mem[{cpage, cidx[PAGE_W-1:0]}] <= pbuf[cidx[PAGE_W-1:0]];
    end
  end

  sea_wrtimer #(.CYCLES(WR_CYCLES)) u_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(commit_go),
    .o_busy(busy)
  );

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_busy_silent;
    busy |-> !o_sda_oe;
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("drive while busy");

  property p_addr_ack;
    byte_done && role == sea_pkg::SEA_ROLE_ADDR && addr_hit |=> o_sda_oe && rw == $past(sr[0]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_word_load;
    word_take |=> ptr == $past(sr) && o_sda_oe;
  endproperty
  a_word_load: assert property (p_word_load) else $error("word pointer not loaded");

  property p_page_inc;
    data_take |=> ptr[PAGE_W-1:0] == PAGE_W'($past(ptr[PAGE_W-1:0]) + 1'b1)
      && ptr[7:PAGE_W] == $past(ptr[7:PAGE_W]) && o_sda_oe;
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page pointer step wrong");

  property p_lock_nack;
    byte_done && role == sea_pkg::SEA_ROLE_DATA && wp |=> !o_sda_oe [*2];
  endproperty
  a_lock_nack: assert property (p_lock_nack) else $error("data acked under lock");

  property p_stop_busy;
    commit_go |=> busy [*8];
  endproperty
  a_stop_busy: assert property (p_stop_busy) else $error("write cycle not started");

  // Length of the running write cycle, counted apart from the timer's own counter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_len <= '0;
    end else if (commit_go) begin
      busy_len <= '0;
    end else if (busy) begin
      busy_len <= busy_len + 1'b1;
    end
  end

  property p_busy_len;
    $fell(busy) |-> busy_len == BW'(WR_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");

  property p_stop_idle;
    stop_ev |=> state == sea_pkg::SEA_IDLE && !o_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no standby after stop");

  property p_read_step;
    rd_load |=> ptr == $past(ptr) + 8'h01 && tx == $past(rd_byte)
      && state == sea_pkg::SEA_SEND;
  endproperty
  a_read_step: assert property (p_read_step) else $error("read pointer step wrong");

  // Copy of each loaded byte, so the bit order is judged apart from the shifter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_ref <= 8'h00;
    end else if (rd_load) begin
      tx_ref <= rd_byte;
    end
  end

  property p_msb_first;
    state == sea_pkg::SEA_SEND && !busy |-> o_sda_oe == ~tx_ref[3'h7 - cnt[2:0]];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("wrong bit on line");

  property p_nack_wait;
    state == sea_pkg::SEA_MACK && scl_rise && sda_s && !busy && !stop_ev && !start_ev
      |=> state == sea_pkg::SEA_WAIT ##1 !o_sda_oe;
  endproperty
  a_nack_wait: assert property (p_nack_wait) else $error("sent after no ack");

  c_commit: cover property (commit_go ##1 busy);
  c_read: cover property (rd_load ##1 state == sea_pkg::SEA_SEND);
  c_poll: cover property (busy && scl_s && scl_q && sda_q && !sda_s);
  c_lock: cover property (byte_done && role == sea_pkg::SEA_ROLE_DATA && wp);
  c_wrap: cover property (rd_load && ptr == 8'hFF);

endmodule // sea_engine

// [core/sea_map.svh]
// Constants for the serial EEPROM access engine: bit counts, reset values, timing.
// Assumes the includer runs on a 40 MHz clock.
`ifndef SEA_MAP_SVH
`define SEA_MAP_SVH

// Bits in one serial byte and last transmit bit index
`define SEA_BYTE_BITS 4'h8
`define SEA_LAST_TX 4'h7

// Direction bit of the slave address byte
`define SEA_RW_POS 0

// Word pointer reset value
`define SEA_PTR_RST 8'h00

// Line idle levels at reset: scl, sda high
`define SEA_SYNC_RST 6'h30

// Internal write cycle time and clock rate
`define SEA_T_WR_NS 5000000
`define SEA_CLK_MHZ 40

`endif

// [core/sea_pkg.sv]
// Types shared by the serial EEPROM access engine.
// Assumes nothing of its surroundings.
package sea_pkg;

  typedef enum logic [2:0] {
    SEA_IDLE, SEA_RECV, SEA_ACK, SEA_SEND, SEA_MACK, SEA_WAIT
  } sea_state_t;

  typedef enum logic [1:0] {
    SEA_ROLE_ADDR, SEA_ROLE_WORD, SEA_ROLE_DATA
  } sea_role_t;

endpackage

// [core/sea_sync.sv]
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/100ps
module sea_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= RST;
      o_q <= RST;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule // sea_sync

// [core/sea_wrtimer.sv]
// Self-timed nonvolatile write cycle counter.
// Assumes i_start is a one-cycle pulse on i_clk.
`timescale 1ns/100ps
module sea_wrtimer #(
  parameter int CYCLES = 200000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  output logic o_busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;

  // Busy stays high for exactly CYCLES clocks after the start pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      cnt <= CW'(CYCLES - 1);
      o_busy <= 1'b1;
    end else if (o_busy) begin
      if (cnt == '0) begin
        o_busy <= 1'b0;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

endmodule // sea_wrtimer

// [testbench/sea_engine_tb_top.sv]
// Self-checking bench for the serial EEPROM access engine.
// Assumes the master model on the link and a short write cycle parameter.
`timescale 1ns/100ps
module sea_engine_tb_top;
  localparam int WR_CYC = 64;
  localparam logic [3:0] DEV_ID = 4'h5; // Arbitrary identifier value
  localparam logic [2:0] STRAPS = 3'h5;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_lock = 1'b0;
  logic sda_o, sda_oe, busy, scl, pull;
  wire sda;
  logic [7:0] exp_mem [256];
  int miscompares = 0;
  int num_checks = 0;

  // Open-drain wire: either party pulling wins, else the pull-up
  assign sda = ((sda_oe && !sda_o) || pull) ? 1'b0 : 1'b1;

  always #12.5 clk = ~clk;

  sea_engine #(.WR_CYCLES(WR_CYC), .DEV_ID(DEV_ID)) dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda),
    .i_write_lock(write_lock), .i_chip_select_straps(STRAPS),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_busy(busy));
  sea_master_model m (.i_sda(sda), .o_scl(scl), .o_pull(pull));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [7:0] addr(input logic rw);
    return {DEV_ID, STRAPS, rw};
  endfunction

  // Keep link steps on the stimulus slot just after a clock edge
  task automatic sync();
    @(posedge clk);
    #1;
  endtask

  // Poll right after stop; a running write cycle must refuse the first poll
  task automatic poll_ready(input logic expect_busy);
    logic ack;
    check({7'h00, busy}, {7'h00, expect_busy});
    for (int n = 0; n < 20; n++) begin
      m.start();
      m.wr_byte(addr(1'b0), ack);
      m.stop();
      if (n == 0) check({7'h00, ack}, {7'h00, ~expect_busy});
      if (ack) break;
    end
    check({7'h00, ack}, 8'h01);
  endtask

  // Write n bytes from word address wa; under lock the first data byte must go unacked
  task automatic write_seq(input logic [7:0] wa, input int n, input logic [7:0] d0,
                           input logic lock);
    logic ack;
    sync();
    write_lock = lock;
    m.start();
    m.wr_byte(addr(1'b0), ack);
    check({7'h00, ack}, 8'h01);
    m.wr_byte(wa, ack);
    check({7'h00, ack}, 8'h01);
    for (int k = 0; k < n; k++) begin
      m.wr_byte(d0 + 8'(k), ack);
      if (k == 0) check({7'h00, ack}, {7'h00, ~lock});
      else check({7'h00, ack}, 8'h01);
      if (!lock) exp_mem[{wa[7:4], wa[3:0] + 4'(k)}] = d0 + 8'(k);
    end
    m.stop();
    sync();
    poll_ready(~lock);
    write_lock = 1'b0;
  endtask

  // Random read of n bytes: dummy write, repeated start, then reading
  task automatic read_seq(input logic [7:0] wa, input int n);
    logic ack;
    logic [7:0] d;
    sync();
    m.start();
    m.wr_byte(addr(1'b0), ack);
    m.wr_byte(wa, ack);
    check({7'h00, ack}, 8'h01);
    m.start();
    m.wr_byte(addr(1'b1), ack);
    check({7'h00, ack}, 8'h01);
    for (int k = 0; k < n; k++) begin
      m.rd_byte(k < n - 1, d);
      check(d, exp_mem[8'(wa + k)]);
    end
    m.stop();
  endtask

  // Address with other straps: no acknowledge, and the line is left alone
  task automatic wrong_addr();
    logic ack;
    logic [7:0] d;
    sync();
    m.start();
    m.wr_byte({DEV_ID, ~STRAPS, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    m.rd_byte(1'b0, d);
    check(d, 8'hFF);
    m.stop();
  endtask

  // Current-address read; the line must be free once the master declines
  task automatic read_current(input logic [7:0] ea);
    logic ack;
    logic [7:0] d;
    sync();
    m.start();
    m.wr_byte(addr(1'b1), ack);
    check({7'h00, ack}, 8'h01);
    m.rd_byte(1'b0, d);
    check(d, exp_mem[ea]);
    #100;
    check({7'h00, sda_oe}, 8'h00);
    m.stop();
  endtask

  // Main sequence: a page overrun, short writes, wrap reads, locked write
  initial begin
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk);
    write_seq(8'h3E, 18, 8'hA0, 1'b0);
    read_seq(8'h30, 16);
    write_seq(8'h30, 2, 8'h50, 1'b0);
    read_seq(8'h30, 4);
    write_seq(8'hFF, 1, 8'h11, 1'b0);
    write_seq(8'h00, 2, 8'h22, 1'b0);
    read_seq(8'hFF, 2);
    wrong_addr();
    read_current(8'h01);
    write_seq(8'h31, 1, 8'hEE, 1'b1);
    read_seq(8'h30, 4);
    finish_test();
  end

  // Watchdog: the whole sequence needs well under half this span
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule // sea_engine_tb_top

// [testbench/sea_master_model.sv]
// Behavioural two-wire bus master that drives the serial link of the engine.
// Assumes a pull-up on sda outside and task calls made just after a system clock edge.
`timescale 1ns/100ps
module sea_master_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high
  // Clock rises a full half period after release, so a slave's pending ack lets go first
  task automatic start();
    o_pull = 1'b0;
    #100 o_scl = 1'b1;
    #100 o_pull = 1'b1;
    #100 o_scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the clock stands still
  task automatic stop();
    #50 o_pull = 1'b1;
    #50 o_scl = 1'b1;
    #100 o_pull = 1'b0;
    #100;
  endtask

  // One 200 ns clock; data moves mid-low, sampled mid-high to clear the reply delay
  task automatic bit_cycle(input logic b, output logic s);
    #50 o_pull = ~b;
    #50 o_scl = 1'b1;
    #50 s = i_sda;
    #50 o_scl = 1'b0;
  endtask

  // Byte out, then the ninth clock with sda released for the reply
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // Byte in, then our own acknowledge or its absence
  task automatic rd_byte(input logic ack_in, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b1, s);
      d = {d[6:0], s};
    end
    bit_cycle(~ack_in, s);
  endtask
endmodule // sea_master_model
